// ===== src/tdmtx_consts.vh
// Constants of the transmit timeslot pointer block
`ifndef TDMTX_CONSTS_VH
`define TDMTX_CONSTS_VH

// Register byte addresses
`define TDMTX_OFS_MAP_LOW 16'ha810
`define TDMTX_OFS_MAP_HIGH 16'ha814
`define TDMTX_OFS_CHAN_COUNT 16'ha820
`define TDMTX_OFS_STATUS 16'ha824

// Pointer field layout: one 5-bit pointer in the low bits of each byte lane
`define TDMTX_PTR_W 5
`define TDMTX_LANE_STRIDE 8
`define TDMTX_LANE_CNT 4
`define TDMTX_PTR_RESET 5'h00

// Channel count field
`define TDMTX_CHAN_W 5
`define TDMTX_CHAN_RESET 5'h00

// Highway slot number width (twice the count plus one fits)
`define TDMTX_SLOT_W 6

// Status register fields
`define TDMTX_ST_SLOT_LSB 0
`define TDMTX_ST_HIGH_BIT 8
`define TDMTX_ST_HIT_BIT 9
`define TDMTX_ST_LANE_LSB 10
`define TDMTX_ST_FRAME_LSB 24

// Byte sent in a slot that no pointer claims
`define TDMTX_IDLE_BYTE 8'hff

`endif

// ===== src/tdmtx_lane_match.v
// Lane search: which byte lane points at the current highway slot
`timescale 1ns/10ps
`include "tdmtx_consts.vh"

module tdmtx_lane_match (
    input wire [5:0] slot,
    input wire [5:0] base,
    input wire [5:0] limit,
    input wire [19:0] ptrs,
    output reg hit,
    output reg [1:0] lane
);

    reg [5:0] target;
    reg in_range;
    integer k;

    // Base added back to each pointer; lowest lane wins on a tie
    always @* begin
        target = 6'h00;
        hit = 1'b0;
        lane = 2'h0;
        in_range = (slot >= base) && (slot <= limit);
        for (k = `TDMTX_LANE_CNT - 1; k >= 0; k = k - 1) begin
            target = {1'b0, ptrs[k*`TDMTX_PTR_W +: `TDMTX_PTR_W]} + base;
            if (in_range && (target == slot)) begin
                hit = 1'b1;
                lane = k[1:0];
            end
        end
    end

endmodule // tdmtx_lane_match

// ===== src/tdmtx_slot_map.v
// Transmit timeslot switch pointers with Avalon-MM register access
//
// Function
// - The low map register holds four 5-bit pointers at bits 4:0, 12:8, 20:16 and 28:24, one per byte lane of the low holding word.
// - The low holding word is only placed in slots 0 up to and including the channel count.
// - The high map register uses the same four pointer positions for the lanes of the high holding word.
// - The high holding word is only placed in slots from count plus one up to twice the count plus one.
// - High pointers are written as an offset from count plus one and the block adds that base back.
// - Every low pointer resets to zero and changes only by a software write.
// - Every high pointer resets to zero and changes only by a software write.
`timescale 1ns/10ps
`include "tdmtx_consts.vh"

module tdmtx_slot_map (
    input wire clk,
    input wire sys_rst,
    input wire [15:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire frame_start,
    input wire slot_tick,
    input wire [31:0] hold_word_low,
    input wire [31:0] hold_word_high,
    output reg [7:0] tx_byte,
    output reg tx_byte_valid,
    output reg tx_from_map,
    output reg tx_from_high
);

    // Bus handshake states, one-hot
    localparam BUS_IDLE = 2'b01;
    localparam BUS_ANSWER = 2'b10;

    reg [1:0] bus_state;
    reg [1:0] next_bus_state;

    // Pointer storage: only the 5 live bits of each lane exist
    reg [19:0] map_low;
    reg [19:0] map_high;
    reg [4:0] channel_count_field;

    // Highway progress
    reg [5:0] slot_cnt;
    reg [7:0] frame_cnt;
    reg last_high;
    reg last_hit;
    reg [1:0] last_lane;

    wire low_hit;
    wire [1:0] low_lane;
    wire high_hit;
    wire [1:0] high_lane;

    reg [5:0] cur_slot;
    reg [5:0] low_limit;
    reg [5:0] high_base;
    reg [5:0] high_limit;
    reg [31:0] read_value;
    reg [31:0] next_readdata;
    reg [19:0] next_map_low;
    reg [19:0] next_map_high;
    reg [4:0] next_channel_count;
    reg [7:0] next_tx_byte;
    reg next_from_map;
    reg next_from_high;
    reg [1:0] next_lane;

    // Pick one byte lane out of a holding word
    function [7:0] lane_byte;
        input [31:0] word;
        input [1:0] lane;
        begin
            case (lane)
                2'h0: lane_byte = word[7:0];
                2'h1: lane_byte = word[15:8];
                2'h2: lane_byte = word[23:16];
                default: lane_byte = word[31:24];
            endcase
        end
    endfunction

    // Merge the byte-enabled lanes of a write into a pointer set
    function [19:0] merge_ptrs;
        input [19:0] old_ptrs;
        input [31:0] wdata;
        input [3:0] ben;
        integer k;
        begin
            merge_ptrs = old_ptrs;
            for (k = 0; k < `TDMTX_LANE_CNT; k = k + 1) begin
                if (ben[k]) begin
                    merge_ptrs[k*`TDMTX_PTR_W +: `TDMTX_PTR_W] =
                        wdata[k*`TDMTX_LANE_STRIDE +: `TDMTX_PTR_W];
                end
            end
        end
    endfunction

    // Spread a pointer set back to lane positions; the read mux does not use it
    function [31:0] spread_ptrs;
        input [19:0] ptrs;
        integer k;
        begin
            spread_ptrs = 32'h00000000;
            for (k = 0; k < `TDMTX_LANE_CNT; k = k + 1) begin
                spread_ptrs[k*`TDMTX_LANE_STRIDE +: `TDMTX_PTR_W] =
                    ptrs[k*`TDMTX_PTR_W +: `TDMTX_PTR_W];
            end
        end
    endfunction

    // Slot windows derived from the channel count
    always @* begin
        low_limit = {1'b0, channel_count_field};
        high_base = {1'b0, channel_count_field} + 6'h01;
        high_limit = {channel_count_field, 1'b1};
        cur_slot = frame_start ? 6'h00 : slot_cnt;
    end

    // Low word search, base zero
    tdmtx_lane_match u_low_match (
        .slot(cur_slot),
        .base(6'h00),
        .limit(low_limit),
        .ptrs(map_low),
        .hit(low_hit),
        .lane(low_lane)
    );

    // High word search, pointers offset by count plus one
    tdmtx_lane_match u_high_match (
        .slot(cur_slot),
        .base(high_base),
        .limit(high_limit),
        .ptrs(map_high),
        .hit(high_hit),
        .lane(high_lane)
    );

    // Read mux; the pointer registers are write-only and read as zero
    always @* begin
        read_value = 32'h00000000;
        case (avs_address)
            `TDMTX_OFS_CHAN_COUNT: begin
                read_value[`TDMTX_CHAN_W-1:0] = channel_count_field;
            end
            `TDMTX_OFS_STATUS: begin
                read_value[`TDMTX_ST_SLOT_LSB +: `TDMTX_SLOT_W] = slot_cnt;
                read_value[`TDMTX_ST_HIGH_BIT] = last_high;
                read_value[`TDMTX_ST_HIT_BIT] = last_hit;
                read_value[`TDMTX_ST_LANE_LSB +: 2] = last_lane;
                read_value[`TDMTX_ST_FRAME_LSB +: 8] = frame_cnt;
            end
            default: begin
                read_value = 32'h00000000;
            end
        endcase
    end

    // Next handshake state
    always @* begin
        next_bus_state = bus_state;
        case (bus_state)
            BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    next_bus_state = BUS_ANSWER;
                end
            end
            BUS_ANSWER: begin
                next_bus_state = BUS_IDLE;
            end
            default: begin
                next_bus_state = BUS_IDLE;
            end
        endcase
    end

    // Read data for the answer cycle; held one cycle past it, then cleared while no read is pending
    always @* begin
        if (bus_state == BUS_IDLE && avs_read) begin
            next_readdata = read_value;
        end else if (bus_state == BUS_ANSWER) begin
            next_readdata = avs_readdata;
        end else begin
            next_readdata = 32'h00000000;
        end
    end

    // One wait state per access; read data latched at the same edge that drops waitrequest
    always @(posedge clk) begin
        if (sys_rst) begin
            bus_state <= BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else begin
            bus_state <= next_bus_state;
            avs_waitrequest <= (next_bus_state != BUS_ANSWER);
            avs_readdata <= next_readdata;
        end
    end

    // Write decode; a write lands only at the edge that sees waitrequest low
    always @* begin
        next_map_low = map_low;
        next_map_high = map_high;
        next_channel_count = channel_count_field;
        if (bus_state == BUS_ANSWER && avs_write) begin
            case (avs_address)
                `TDMTX_OFS_MAP_LOW: begin
                    next_map_low = merge_ptrs(map_low, avs_writedata, avs_byteenable);
                end
                `TDMTX_OFS_MAP_HIGH: begin
                    next_map_high = merge_ptrs(map_high, avs_writedata, avs_byteenable);
                end
                `TDMTX_OFS_CHAN_COUNT: begin
                    if (avs_byteenable[0]) begin
                        next_channel_count = avs_writedata[`TDMTX_CHAN_W-1:0];
                    end
                end
                default: begin
                    // Unmapped or read-only: write dropped
                    next_channel_count = channel_count_field;
                end
            endcase
        end
    end

    // Pointer and count registers; nothing but a bus write moves them
    always @(posedge clk) begin
        if (sys_rst) begin
            map_low <= {4{`TDMTX_PTR_RESET}};
            map_high <= {4{`TDMTX_PTR_RESET}};
            channel_count_field <= `TDMTX_CHAN_RESET;
        end else begin
            map_low <= next_map_low;
            map_high <= next_map_high;
            channel_count_field <= next_channel_count;
        end
    end

    // Slot counter; a frame start marks its tick as slot 0
    always @(posedge clk) begin
        if (sys_rst) begin
            slot_cnt <= 6'h00;
            frame_cnt <= 8'h00;
        end else if (slot_tick) begin
            slot_cnt <= cur_slot + 6'h01; // Wraps at 64, never reached in use
            if (frame_start) begin
                frame_cnt <= frame_cnt + 8'h01;
            end
        end else if (frame_start) begin
            slot_cnt <= 6'h00;
        end
    end

    // Placement decision; low word has priority should both windows claim a slot
    always @* begin
        next_tx_byte = `TDMTX_IDLE_BYTE;
        next_from_map = 1'b0;
        next_from_high = 1'b0;
        next_lane = last_lane;
        if (low_hit) begin
            next_tx_byte = lane_byte(hold_word_low, low_lane);
            next_from_map = 1'b1;
            next_lane = low_lane;
        end else if (high_hit) begin
            next_tx_byte = lane_byte(hold_word_high, high_lane);
            next_from_map = 1'b1;
            next_from_high = 1'b1;
            next_lane = high_lane;
        end else begin
            // Unclaimed slot carries the idle pattern
            next_tx_byte = `TDMTX_IDLE_BYTE;
        end
    end

    // Output flops other than tx_byte_valid move only on a tick, so a byte stands until the next slot
    always @(posedge clk) begin
        if (sys_rst) begin
            tx_byte <= `TDMTX_IDLE_BYTE;
            tx_byte_valid <= 1'b0;
            tx_from_map <= 1'b0;
            tx_from_high <= 1'b0;
            last_high <= 1'b0;
            last_hit <= 1'b0;
            last_lane <= 2'h0;
        end else begin
            tx_byte_valid <= slot_tick;
            if (slot_tick) begin
                tx_byte <= next_tx_byte;
                tx_from_map <= next_from_map;
                tx_from_high <= next_from_high;
                last_lane <= next_lane;
                last_high <= next_from_high;
                last_hit <= next_from_map;
            end
        end
    end

endmodule // tdmtx_slot_map

// ===== sim/tdmtx_slot_map_monitor.sv
// Assertion checker for the transmit slot pointer block
`timescale 1ns/10ps
`include "tdmtx_consts.vh"
module tdmtx_chk (
    input logic clk,
    input logic sys_rst,
    input logic [15:0] avs_address,
    input logic avs_read,
    input logic avs_write,
    input logic [31:0] avs_writedata,
    input logic [3:0] avs_byteenable,
    input logic [31:0] avs_readdata,
    input logic avs_waitrequest,
    input logic frame_start,
    input logic slot_tick,
    input logic [31:0] hold_word_low,
    input logic [31:0] hold_word_high,
    input logic [7:0] tx_byte,
    input logic tx_byte_valid,
    input logic tx_from_map,
    input logic tx_from_high
);
    logic [19:0] lo, hi;
    logic [4:0] cnt;
    logic [5:0] slot, cur;
    logic lo_hit, hi_hit;
    logic [7:0] lo_b, hi_b;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Shadow of the pointers; reserved bits are never copied
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lo <= 20'h00000;
            hi <= 20'h00000;
            cnt <= 5'h00;
        end else if (avs_write && !avs_waitrequest) begin
            for (int k = 0; k < 4; k++) begin
                if (avs_byteenable[k] && avs_address == `TDMTX_OFS_MAP_LOW) lo[k*5+:5] <= avs_writedata[k*8+:5];
                if (avs_byteenable[k] && avs_address == `TDMTX_OFS_MAP_HIGH) hi[k*5+:5] <= avs_writedata[k*8+:5];
            end
            if (avs_byteenable[0] && avs_address == `TDMTX_OFS_CHAN_COUNT) cnt <= avs_writedata[4:0];
        end
    end
    // Slot counter of the highway
    always_ff @(posedge clk) begin
        if (sys_rst || (frame_start && !slot_tick)) slot <= 6'h00;
        else if (slot_tick) slot <= cur + 6'h01;
    end
    // Highest lane first, so the lowest matching lane wins
    always_comb begin
        cur = frame_start ? 6'h00 : slot;
        lo_hit = 1'b0;
        hi_hit = 1'b0;
        lo_b = 8'h00;
        hi_b = 8'h00;
        for (int k = 3; k >= 0; k--) begin
            if (cur <= {1'b0, cnt} && {1'b0, lo[k*5+:5]} == cur) begin
                lo_hit = 1'b1;
                lo_b = hold_word_low[k*8+:8];
            end
            if (cur > {1'b0, cnt} && cur <= {cnt, 1'b1} && hi[k*5+:5] + cnt + 6'h01 == cur) begin
                hi_hit = 1'b1;
                hi_b = hold_word_high[k*8+:8];
            end
        end
    end
    sequence one_wait;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> one_wait)
        else $error("bus wait wrong");
    map_read_zero_a: assert property (avs_read && avs_waitrequest &&
        (avs_address == `TDMTX_OFS_MAP_LOW || avs_address == `TDMTX_OFS_MAP_HIGH) |=> avs_readdata == 32'h00000000)
        else $error("map read not zero");
    low_lane_a: assert property (slot_tick && lo_hit |=> tx_from_map && !tx_from_high && tx_byte == $past(lo_b))
        else $error("low byte wrong");
    high_lane_a: assert property (slot_tick && !lo_hit && hi_hit |=> tx_from_high && tx_byte == $past(hi_b))
        else $error("high byte wrong");
    idle_slot_a: assert property (slot_tick && !lo_hit && !hi_hit |=> !tx_from_map && tx_byte == `TDMTX_IDLE_BYTE)
        else $error("idle byte wrong");
    valid_pulse_a: assert property (tx_byte_valid == $past(slot_tick))
        else $error("valid pulse wrong");
    output_hold_a: assert property (!slot_tick |=> $stable(tx_byte) && $stable(tx_from_high))
        else $error("byte not held");
    reset_state_a: assert property ($fell(sys_rst) |-> avs_waitrequest && !tx_from_map && !tx_from_high &&
        !tx_byte_valid && tx_byte == `TDMTX_IDLE_BYTE)
        else $error("reset state wrong");
endmodule // tdmtx_chk

// ===== sim/tdmtx_highway.sv
// Highway partner: ticks slots and captures the bytes sent
`timescale 1ns/10ps
module tdmtx_highway (
    input logic clk,
    input logic sys_rst,
    input logic go,
    input logic gap,
    input logic [5:0] nslots,
    input logic [7:0] tx_byte,
    input logic tx_byte_valid,
    output logic frame_start,
    output logic slot_tick,
    output logic busy
);
    logic [7:0] seen [0:63];
    logic [5:0] sent, got;
    logic idle;
    // With gap set, one idle cycle follows every tick
    always_ff @(posedge clk) begin
        slot_tick <= 1'b0;
        frame_start <= 1'b0;
        if (sys_rst) begin
            busy <= 1'b0;
        end else if (go) begin
            busy <= 1'b1;
            sent <= 6'h00;
            got <= 6'h00;
            idle <= 1'b0;
        end else if (busy) begin
            if (tx_byte_valid) seen[got] <= tx_byte;
            got <= got + {5'h00, tx_byte_valid};
            slot_tick <= sent < nslots && !idle;
            frame_start <= sent == 6'h00;
            sent <= sent + {5'h00, sent < nslots && !idle};
            idle <= gap && !idle;
            busy <= got != nslots;
        end
    end
endmodule // tdmtx_highway

// ===== sim/tb_tdmtx_slot_map.sv
// Self-checking bench for the transmit slot pointer block
`timescale 1ns/10ps
`include "tdmtx_consts.vh"
module tb_tdmtx_slot_map;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] adr = 16'h0000;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h00000000;
    logic [3:0] be = 4'hf;
    logic [31:0] hl = 32'h44332211;
    logic [31:0] hh = 32'h88776655;
    logic go = 1'b0;
    logic gap = 1'b0;
    logic [5:0] ns = 6'h00;
    logic [31:0] rdd, q, lo_w, hi_w;
    logic [7:0] txb;
    logic wait_n, fs, tk, vld, fm, fh, busy;
    logic [4:0] cnt;
    int failures = 0;
    int n_compared = 0;
    always #25 clk = ~clk;
    tdmtx_slot_map tdmtx_slot_map_i (.clk(clk), .sys_rst(sys_rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdd), .avs_waitrequest(wait_n), .frame_start(fs),
        .slot_tick(tk), .hold_word_low(hl), .hold_word_high(hh), .tx_byte(txb), .tx_byte_valid(vld),
        .tx_from_map(fm), .tx_from_high(fh));
    tdmtx_highway tdmtx_highway_i (.clk(clk), .sys_rst(sys_rst), .go(go), .gap(gap), .nslots(ns), .tx_byte(txb),
        .tx_byte_valid(vld), .frame_start(fs), .slot_tick(tk), .busy(busy));
    task automatic close_out;
        $display("Compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Request held until waitrequest is seen low at an edge
    task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk);
            t++;
        end while (wait_n !== 1'b0 && t < 20);
        q = rdd;
        wr <= 1'b0;
        rd <= 1'b0;
        if (wait_n !== 1'b0) begin
            failures++;
            close_out();
        end
    endtask
    // Expected byte; low claims beat high ones
    function automatic logic [7:0] exp_slot(input logic [5:0] s);
        exp_slot = `TDMTX_IDLE_BYTE;
        for (int k = 3; k >= 0; k--) begin
            if (s > cnt && s <= {cnt, 1'b1} && hi_w[k*8+:5] + cnt + 6'h01 == s) exp_slot = hh[k*8+:8];
        end
        for (int k = 3; k >= 0; k--) begin
            if (s <= cnt && lo_w[k*8+:5] == s) exp_slot = hl[k*8+:8];
        end
    endfunction
    task automatic frame(input logic g, input logic [5:0] n);
        int t;
        t = 0;
        @(posedge clk);
        go <= 1'b1;
        gap <= g;
        ns <= n;
        @(posedge clk);
        go <= 1'b0;
        do begin
            @(posedge clk);
            t++;
        end while (busy !== 1'b0 && t < 300);
        if (busy !== 1'b0) begin
            failures++;
            close_out();
        end
        for (int s = 0; s < n; s++) chk("slot byte", {24'h0, exp_slot(6'(s))}, {24'h0, tdmtx_highway_i.seen[s]});
    endtask
    initial begin
        lo_w = 32'h0;
        hi_w = 32'h0;
        cnt = 5'h00;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        acc(1'b0, `TDMTX_OFS_MAP_LOW, 32'h0);
        chk("low map read", 32'h0, q);
        acc(1'b0, `TDMTX_OFS_MAP_HIGH, 32'h0);
        chk("high map read", 32'h0, q);
        acc(1'b0, 16'ha800, 32'h0);
        chk("unmapped read", 32'h0, q);
        frame(1'b0, 6'h04);
        lo_w = 32'he7e5e3e1;
        hi_w = 32'he7e5e2e0;
        cnt = 5'h07;
        acc(1'b1, `TDMTX_OFS_CHAN_COUNT, {27'h0, cnt});
        acc(1'b1, `TDMTX_OFS_MAP_LOW, lo_w);
        acc(1'b1, `TDMTX_OFS_MAP_HIGH, hi_w);
        acc(1'b0, `TDMTX_OFS_MAP_LOW, 32'h0);
        chk("low map read", 32'h0, q);
        frame(1'b1, 6'h14);
        cnt = 5'h03;
        acc(1'b1, `TDMTX_OFS_CHAN_COUNT, {27'h0, cnt});
        acc(1'b0, `TDMTX_OFS_CHAN_COUNT, 32'h0);
        chk("count read", {27'h0, cnt}, q);
        // Lane 1 only; the other lanes would land out of window if the enables were ignored
        hi_w[15:8] = 8'h03;
        be <= 4'h2;
        acc(1'b1, `TDMTX_OFS_MAP_HIGH, 32'hffff03ff);
        be <= 4'hf;
        frame(1'b0, 6'h0a);
        acc(1'b0, `TDMTX_OFS_STATUS, 32'h0);
        chk("status", (32'h3 << `TDMTX_ST_FRAME_LSB) | (32'h1 << `TDMTX_ST_LANE_LSB) | 32'h0000000a, q);
        // Second reset must clear every pointer again
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        lo_w = 32'h0;
        hi_w = 32'h0;
        cnt = 5'h00;
        frame(1'b0, 6'h04);
        close_out();
    end
endmodule // tb_tdmtx_slot_map
bind tdmtx_slot_map tdmtx_chk tdmtx_chk_i (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .frame_start(frame_start),
    .slot_tick(slot_tick), .hold_word_low(hold_word_low), .hold_word_high(hold_word_high), .tx_byte(tx_byte),
    .tx_byte_valid(tx_byte_valid), .tx_from_map(tx_from_map), .tx_from_high(tx_from_high));
